// file: src/rxdma_pkg.sv
// Overview of operation
// - rising reset bit restarts read channel
// - enable bit gates all dma requests
// - request only when selected buffer holds message
// - words flow from hdlc buffers to bus
// - transfer begins with request driven low
// - read strobe mode: word per low strobe
// - direction mode: word per write strobe
// - type bit zero: read pin strobes
// - type bit one: read pin is direction
// - three-bit field selects one of eight channels
package rxdma_pkg;
    // register map, byte addresses on apb
    localparam logic [11:0] RXDMA_CFG_ADDR    = 12'h000;
    localparam logic [11:0] RXDMA_STATUS_ADDR = 12'h004;
    // configuration field positions
    localparam int RXDMA_RST_BIT  = 7;
    localparam int RXDMA_ENB_BIT  = 6;
    localparam int RXDMA_TYPE_BIT = 5;
    localparam int RXDMA_CHAN_LSB = 0;
    localparam int RXDMA_CHAN_W   = 3;
    localparam int RXDMA_NCHAN    = 8;
    localparam logic [7:0] RXDMA_CFG_RESET = 8'h00;
    localparam logic [7:0] RXDMA_CFG_MASK  = 8'hE7;
    // source word width
    localparam int RXDMA_DW = 8;

    // configuration as a struct
    typedef struct packed {
        logic                    rst;
        logic                    enb;
        logic                    rd_type;
        logic [1:0]              rsvd;
        logic [RXDMA_CHAN_W-1:0] chan;
    } rxdma_cfg_t;

    // request handshake states
    typedef enum logic [1:0] {
        RXDMA_IDLE,
        RXDMA_REQ,
        RXDMA_XFER
    } rxdma_state_t;

    // one word from the hdlc buffer with its end-of-message mark
    typedef struct packed {
        logic                eom;
        logic [RXDMA_DW-1:0] data;
    } rxdma_word_t;
endpackage

// file: src/rxdma_read.sv
// receive read dma channel: hdlc buffer words out onto the host bus
module rxdma_read
    import rxdma_pkg::*;
#(
    parameter int NCHAN = RXDMA_NCHAN
)
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // per-channel hdlc receive buffer side
    input  wire logic [NCHAN-1:0]     msg_ready,
    input  wire logic [NCHAN-1:0]     src_valid,
    input  wire rxdma_word_t          src_word [NCHAN],
    output logic      [NCHAN-1:0]     src_ready,
    // dma pins
    output logic                      rx_dma_request_n,
    input  wire logic                 rx_dma_acknowledge_n,
    input  wire logic                 rd_n,
    input  wire logic                 wr_n,
    output logic      [RXDMA_DW-1:0]  dbus_out,
    output logic                      dbus_oe
);
    // software config register
    rxdma_cfg_t   cfg;
    rxdma_cfg_t   next_cfg;
    // apb answer registers
    logic [31:0]  next_prdata;
    logic         next_pready;
    logic         next_pslverr;
    // channel reset pulse from the 0->1 write
    logic         chan_rst;
    logic         next_chan_rst;
    // handshake state
    rxdma_state_t state;
    rxdma_state_t next_state;
    logic         req_n;
    logic         next_req_n;
    // two-entry skid buffer
    rxdma_word_t  buf_mem [2];
    rxdma_word_t  next_buf_mem [2];
    logic [1:0]   buf_cnt;
    logic [1:0]   next_buf_cnt;
    logic         buf_rd;
    logic         next_buf_rd;
    // strobe edge tracking
    logic         strb_q;
    logic         next_strb_q;
    logic [RXDMA_DW-1:0] dout;
    logic [RXDMA_DW-1:0] next_dout;
    logic         oe;
    logic         next_oe;
    logic [NCHAN-1:0] next_src_ready;
    logic [NCHAN-1:0] src_rdy_q;

    // combinational helpers
    logic         strb_n;
    logic         strb_fall;
    logic         in_valid;
    rxdma_word_t  in_word;
    logic         push;
    logic         pop;
    logic         apb_acc;

    // decode used three times: one-hot of the selected channel
    function automatic logic [NCHAN-1:0] chan_onehot(
        input logic [RXDMA_CHAN_W-1:0] c
    );
        logic [NCHAN-1:0] r;
        r = '0;
        r[c] = 1'b1;
        return r;
    endfunction

    // strobe choice: the type bit picks which pin carries the strobe
    always_comb
    begin
        strb_n    = cfg.rd_type ? wr_n : rd_n;
        strb_fall = strb_q & ~strb_n & ~rx_dma_acknowledge_n;
        in_valid  = |(src_valid & chan_onehot(cfg.chan));
        in_word   = src_word[cfg.chan];
        apb_acc   = psel & penable & ~pready;
    end

    // apb register access and reset-bit edge
    always_comb
    begin
        next_cfg      = cfg;
        next_prdata   = prdata;
        next_pslverr  = 1'b0;
        next_pready   = apb_acc;
        next_chan_rst = 1'b0;
        if (apb_acc)
        begin
            if (paddr == RXDMA_CFG_ADDR)
            begin
                if (pwrite)
                begin
                    next_cfg = rxdma_cfg_t'(pwdata[7:0] & RXDMA_CFG_MASK);
                    next_chan_rst = pwdata[RXDMA_RST_BIT] & ~cfg.rst;
                end
                else
                begin
                    next_prdata = {24'h0000_00, cfg};
                end
            end
            else if (paddr == RXDMA_STATUS_ADDR && !pwrite)
            begin
                // live handshake state for software
                next_prdata = {28'h0000_000, buf_cnt,
                               ~req_n, state != RXDMA_IDLE};
            end
            else
            begin
                // unmapped or write to status: error, no effect
                next_pslverr = 1'b1;
                next_prdata  = 32'h0000_0000;
            end
        end
    end

    // request handshake and buffer
    always_comb
    begin
        next_state   = state;
        next_req_n   = req_n;
        next_buf_mem = buf_mem;
        next_buf_cnt = buf_cnt;
        next_buf_rd  = buf_rd;
        next_dout    = dout;
        // finish a strobe already begun, even past the last word
        next_oe      = oe & ~strb_n & ~rx_dma_acknowledge_n;
        next_strb_q  = strb_n;
        // pull from hdlc buffer while room
        push = src_rdy_q != '0 && in_valid;
        pop  = strb_fall && buf_cnt != 2'd0 && state == RXDMA_XFER;
        next_src_ready = '0;
        unique case (state)
            RXDMA_IDLE:
            begin
                // only when enabled and message waiting
                if (cfg.enb && (msg_ready & chan_onehot(cfg.chan)) != '0)
                begin
                    next_req_n = 1'b0;
                    next_state = RXDMA_REQ;
                end
            end
            RXDMA_REQ:
            begin
                if (!rx_dma_acknowledge_n)
                    next_state = RXDMA_XFER;
            end
            RXDMA_XFER:
            begin
                next_oe = ~strb_n & ~rx_dma_acknowledge_n;
                if (pop)
                begin
                    next_dout = buf_mem[buf_rd].data;
                    next_buf_rd = ~buf_rd;
                    // last word of message ends request
                    if (buf_mem[buf_rd].eom)
                    begin
                        next_req_n = 1'b1;
                        next_state = RXDMA_IDLE;
                    end
                end
            end
        endcase
        if (push)
        begin
            next_buf_mem[buf_rd ^ (buf_cnt != 2'd0)] = in_word;
        end
        next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
        // back-pressure: ready only with a free slot next cycle
        if (state != RXDMA_IDLE && next_buf_cnt != 2'd2)
            next_src_ready = chan_onehot(cfg.chan);
        if (!cfg.enb || chan_rst)
        begin
            next_state     = RXDMA_IDLE;
            next_req_n     = 1'b1;
            next_buf_cnt   = 2'd0;
            next_buf_rd    = 1'b0;
            next_oe        = 1'b0;
            next_src_ready = '0;
        end
    end

    // register everything
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg       <= rxdma_cfg_t'(RXDMA_CFG_RESET);
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            chan_rst  <= 1'b0;
            state     <= RXDMA_IDLE;
            req_n     <= 1'b1;
            buf_mem   <= '{default: '0};
            buf_cnt   <= 2'd0;
            buf_rd    <= 1'b0;
            strb_q    <= 1'b1;
            dout      <= '0;
            oe        <= 1'b0;
            src_rdy_q <= '0;
        end
        else
        begin
            cfg       <= next_cfg;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            chan_rst  <= next_chan_rst;
            state     <= next_state;
            req_n     <= next_req_n;
            buf_mem   <= next_buf_mem;
            buf_cnt   <= next_buf_cnt;
            buf_rd    <= next_buf_rd;
            strb_q    <= next_strb_q;
            dout      <= next_dout;
            oe        <= next_oe;
            src_rdy_q <= next_src_ready;
        end
    end

    assign rx_dma_request_n = req_n;
    assign src_ready        = src_rdy_q;
    assign dbus_out         = dout;
    assign dbus_oe          = oe;

    // assertions
    // disabled channel never requests
    req_needs_enable_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !cfg.enb |=> req_n)
        else $error("request while disabled");
    // reset pulse clears request next edge
    rst_drops_req_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        chan_rst |=> req_n && state == RXDMA_IDLE)
        else $error("reset did not clear request");
    // request only with a waiting message
    req_needs_msg_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(req_n) |-> $past(msg_ready[cfg.chan]))
        else $error("request without message");
    // buffer never overfills
    buf_bound_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        buf_cnt <= 2'd2)
        else $error("buffer overflow");
    // request low through a transfer
    xfer_req_low_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == RXDMA_XFER |-> !req_n)
        else $error("transfer without request");
    // bus drive starts only while transferring
    oe_in_xfer_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $rose(oe) |-> $past(state) == RXDMA_XFER)
        else $error("bus driven outside transfer");
    // bus driven only under a low strobe with ack
    oe_under_strobe_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        oe |-> $past(!strb_n && !rx_dma_acknowledge_n))
        else $error("bus driven without strobe");
    // source ready only with a free buffer slot
    src_room_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        src_rdy_q != '0 |-> buf_cnt != 2'd2)
        else $error("source ready with full buffer");
    // no ack, no transfer state
    ack_gate_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == RXDMA_REQ && rx_dma_acknowledge_n |=> state != RXDMA_XFER)
        else $error("transfer without ack");
    // end of message releases request
    eom_release_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        pop && buf_mem[buf_rd].eom |=> req_n)
        else $error("request held after message end");
    // apb answers one cycle after access
    apb_ready_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule

// file: verification/rxdma_ctrl_model.sv
// behavioural external dma controller facing the read channel
module rxdma_ctrl_model
    import rxdma_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                go,
    input  wire logic                rd_type,
    input  wire logic [3:0]          ack_delay,
    input  wire logic                rx_dma_request_n,
    input  wire logic                dbus_oe,
    input  wire logic [RXDMA_DW-1:0] dbus_out,
    output logic                     rx_dma_acknowledge_n,
    output logic                     rd_n,
    output logic                     wr_n,
    output logic      [31:0]         got,
    output logic      [3:0]          n_got
);
    logic [3:0] wait_cnt; // ack latency, lets the bench play slow
    logic [2:0] ph;       // eight cycles a word, gives buffer time to fill
    logic       low;      // strobe low in the coming phase
    assign low = 3'(ph + 3'd1) >= 3'd5;

    // handshake and strobes, all moved just after the rising edge
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst || !go)
        begin
            rx_dma_acknowledge_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            wait_cnt <= 4'h0;
            ph <= 3'h0;
            got <= 32'h0000_0000;
            n_got <= 4'h0;
        end
        else if (rx_dma_acknowledge_n)
        begin
            if (!rx_dma_request_n && wait_cnt == ack_delay)
                rx_dma_acknowledge_n <= 1'b0;
            else if (!rx_dma_request_n)
                wait_cnt <= wait_cnt + 4'h1;
        end
        // release only between words, never mid-strobe
        else if (rx_dma_request_n && ph == 3'h0)
        begin
            rx_dma_acknowledge_n <= 1'b1;
            wait_cnt <= 4'h0;
        end
        else
        begin
            ph <= ph + 3'h1;
            // read pin strobes in type zero
            rd_n <= rd_type | !low;
            // write pin strobes, read pin held as direction
            wr_n <= !rd_type | !low;
            // word taken only where the device drives the bus
            if (ph == 3'h7 && dbus_oe)
            begin
                got <= {got[23:0], dbus_out};
                n_got <= n_got + 4'h1;
            end
        end
    end
endmodule

// file: verification/testbench.sv
// register and dma tests of the receive read channel
module testbench
    import rxdma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clock, sys_rst, psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, q, got;
    logic              pready, pslverr, e, go, rd_type, dbus_oe;
    logic [7:0]        msg_ready, src_valid, src_ready, ready_mask, w;
    logic [7:0]        dbus_out;
    logic [3:0]        ack_delay, n_got;
    logic              rx_dma_request_n, rx_dma_acknowledge_n, rd_n, wr_n;
    rxdma_word_t       src_word [8];
    int                idx [8];
    int                fail_count, checks;

    rxdma_read uut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .msg_ready, .src_valid,
        .src_word, .src_ready, .rx_dma_request_n, .rx_dma_acknowledge_n,
        .rd_n, .wr_n, .dbus_out, .dbus_oe);
    rxdma_ctrl_model ctl (.clock, .sys_rst, .go, .rd_type, .ack_delay,
        .rx_dma_request_n, .dbus_oe, .dbus_out, .rx_dma_acknowledge_n,
        .rd_n, .wr_n, .got, .n_got);

    // hdlc buffers: three words a message, last one marked
    always_comb
        for (int c = 0; c < 8; c++)
        begin
            msg_ready[c] = ready_mask[c] && idx[c] < 3;
            src_valid[c] = msg_ready[c];
            src_word[c] = '{eom: idx[c] == 2, data: 8'(c * 16 + idx[c])};
        end
    // pop on handshake, clearing the mask rewinds the message
    always @(posedge clock)
        for (int c = 0; c < 8; c++)
            if (!ready_mask[c])
                idx[c] <= 0;
            else if (src_valid[c] && src_ready[c])
                idx[c] <= idx[c] + 1;

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            fail_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for a request level
    task automatic wait_req(input logic lvl);
        for (int n = 0; n < 200 && rx_dma_request_n !== lvl; n++)
            @(posedge clock);
        check("request_n", rx_dma_request_n, lvl);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog far beyond the expected few hundred cycles
    initial
    begin
        #(50 * 20000);
        fail_count++;
        conclude;
    end

    initial
    begin
        {sys_rst, psel, penable, pwrite, go, rd_type} = 6'b100000;
        {paddr, pwdata, ready_mask, ack_delay} = '0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        apb(0, RXDMA_CFG_ADDR, 0);
        check("cfg reset", q, 32'h0000_0000);
        apb(1, RXDMA_CFG_ADDR, 32'hFFFF_FFFF);
        apb(0, RXDMA_CFG_ADDR, 0);
        check("cfg bits", q, {24'h0, RXDMA_CFG_MASK});
        apb(1, RXDMA_CFG_ADDR, 0);
        apb(0, RXDMA_STATUS_ADDR, 0);
        check("status", q, 32'h0000_0000);
        apb(1, 12'h008, 0);
        check("unmapped", e, 1);
        apb(1, RXDMA_STATUS_ADDR, 0);
        check("status write", e, 1);
        $display("register test done");
        // ready buffer but channel off, then wrong channel
        ready_mask <= 8'h01;
        repeat (10) @(posedge clock);
        check("off", rx_dma_request_n, 1);
        apb(1, RXDMA_CFG_ADDR, 32'h41);
        repeat (10) @(posedge clock);
        check("other chan", rx_dma_request_n, 1);
        // reset bit and disable both withdraw a request
        ready_mask <= 8'h04;
        apb(1, RXDMA_CFG_ADDR, 32'h42);
        wait_req(0);
        ready_mask <= 8'h00;
        apb(1, RXDMA_CFG_ADDR, 32'hC2);
        wait_req(1);
        ready_mask <= 8'h04;
        apb(1, RXDMA_CFG_ADDR, 32'h42);
        wait_req(0);
        apb(1, RXDMA_CFG_ADDR, 32'h02);
        wait_req(1);
        ready_mask <= 8'h00;
        $display("control test done");
        // every channel, both pin types, prompt and slow controller
        for (int c = 0; c < 8; c++)
        begin
            go <= 1'b1;
            rd_type <= c[0];
            ack_delay <= c[1] ? 4'h5 : 4'h0;
            ready_mask <= 8'(1 << c) | 8'(1 << ((c + 3) % 8));
            apb(1, RXDMA_CFG_ADDR, {26'h0, c[0], 2'b00, 3'(c)} | 32'h40);
            wait_req(0);
            wait_req(1);
            repeat (10) @(posedge clock);
            w = 8'(c * 16);
            check("words", got, {8'h00, w, w + 8'h01, w + 8'h02});
            check("count", n_got, 3);
            go <= 1'b0;
            ready_mask <= 8'h00;
            // let the model and sources clear before the next channel
            @(posedge clock);
        end
        $display("transfer test done");
        conclude;
    end
endmodule
